// File: verilog/usp_params.svh
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define USP_CLK_HZ 100000000
// Async: baud ticks per bit, so bit rate stays at or below a clock eighth
`define USP_OVERSAMPLE 8
`define USP_PHASE_LAST 3'h7
// Samples taken for the majority vote, centred on the bit
`define USP_VOTE_A 3'h3
`define USP_VOTE_B 3'h4
`define USP_VOTE_C 3'h5
// Infrared modulator: top rate and the least divider it implies (rounded up)
`define USP_IR_MAX_BPS 115200
`define USP_IR_MIN_DIV ((`USP_CLK_HZ + `USP_IR_MAX_BPS * `USP_OVERSAMPLE - 1) / (`USP_IR_MAX_BPS * `USP_OVERSAMPLE))
`define USP_IR_PULSE_A 3'h3
`define USP_IR_PULSE_B 3'h4
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define USP_MIN_BITS 4'h5
`define USP_MAX_BITS 4'h9
`define USP_WORD_W 9
`define USP_FRAME_W 13
`define USP_FIFO_DEPTH 32
`define USP_DIV_W 12
`endif

// File: verilog/usp_pkg.sv
package usp_pkg;
  // Operating mode, Gray coded
  typedef enum logic [1:0] {
    USP_MODE_ASYNC = 2'h0,
    USP_MODE_SYNC = 2'h1,
    USP_MODE_SPI = 2'h3
  } usp_mode_t;
  // Receive sequence, Gray coded along the frame
  typedef enum logic [2:0] {
    USP_RX_IDLE = 3'h0,
    USP_RX_START = 3'h1,
    USP_RX_BITS = 3'h3,
    USP_RX_PAR = 3'h2,
    USP_RX_STOP = 3'h6
  } usp_rx_state_t;
endpackage

// File: verilog/usp_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
// Valid/ready word stream between the block's own modules
interface usp_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// File: verilog/usp_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
module usp_baud_gen import usp_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_in,
  input wire logic [DIV_W-1:0] div_int_in,
  input wire logic [3:0] div_frac_in,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_reg;
  logic [3:0] acc_reg;
  // Fraction accumulates in sixteenths; carry stretches one period
  wire [4:0] acc_sum = {1'b0, acc_reg} + {1'b0, div_frac_in};
  wire [DIV_W-1:0] div_eff = (div_int_in == '0) ? DIV_W'(1) : div_int_in;
  wire wrap = (cnt_reg == '0);
  wire [DIV_W-1:0] reload = div_eff - DIV_W'(1) + DIV_W'(acc_sum[4]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      acc_reg <= 4'h0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg <= '0;
      acc_reg <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= wrap;
      cnt_reg <= wrap ? reload : cnt_reg - DIV_W'(1);
      if (wrap) begin
        acc_reg <= acc_sum[3:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tick_spacing: assert property ((tick_out && run_in && div_int_in > DIV_W'(1) && $stable(div_int_in)) |=> !tick_out) else $error("baud ticks too close");
endmodule
`default_nettype wire

// File: verilog/usp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module usp_fifo import usp_pkg::*; #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  usp_stream_if.snk wr,
  usp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic ready_reg;
  logic valid_reg;
  wire push = wr.valid && ready_reg;
  wire pop = valid_reg && rd.ready;
  wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  assign wr.ready = ready_reg;
  assign rd.valid = valid_reg;
  assign rd.data = mem[rp_reg];

  // Storage, written only on accepted pushes
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= wr.data;
    end
  end

  // Pointers and flags; full and empty are registered so ports see flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
      valid_reg <= 1'b0;
    end else begin
      wp_reg <= push ? wp_reg + AW'(1) : wp_reg;
      rp_reg <= pop ? rp_reg + AW'(1) : rp_reg;
      cnt_reg <= cnt_next;
      ready_reg <= (cnt_next != (AW+1)'(DEPTH));
      valid_reg <= (cnt_next != '0);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fifo_count_up: assert property ((push && !pop) |=> cnt_reg == $past(cnt_reg) + (AW+1)'(1)) else $error("fifo count lost a push");
  a_fifo_full_stall: assert property ((cnt_reg == (AW+1)'(DEPTH)) |-> !wr.ready) else $error("fifo accepts when full");
  c_fifo_fills: cover property (cnt_reg == (AW+1)'(DEPTH));
endmodule
`default_nettype wire

// File: verilog/usp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "usp_params.svh"
module usp_serial_port import usp_pkg::*; #(
  parameter int IR_PRESENT = 1,
  parameter int FIFO_DEPTH = `USP_FIFO_DEPTH,
  parameter int DIV_W = `USP_DIV_W
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  // Configuration
  input wire logic TX_EN_IN,
  input wire logic RX_EN_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic SYNC_SLAVE_IN,
  input wire logic [3:0] DATA_BITS_IN,
  input wire logic TWO_STOP_IN,
  input wire logic PARITY_EN_IN,
  input wire logic PARITY_ODD_IN,
  input wire logic MPCM_IN,
  input wire logic IR_EN_IN,
  input wire logic [DIV_W-1:0] BAUD_INT_IN,
  input wire logic [3:0] BAUD_FRAC_IN,
  // Transmit words
  input wire logic [`USP_WORD_W-1:0] TX_DATA_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  // Received words and status
  output logic [`USP_WORD_W-1:0] RX_DATA_OUT,
  output logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  output logic RX_FRAME_ERR_OUT,
  output logic RX_PARITY_ERR_OUT,
  output logic OVERRUN_OUT,
  input wire logic OVERRUN_CLR_IN,
  // Interrupt requests
  output logic TXC_IRQ_OUT,
  input wire logic TXC_CLR_IN,
  output logic DRE_IRQ_OUT,
  output logic RXC_IRQ_OUT,
  // Serial pins
  input wire logic RXD_IN,
  output logic TXD_OUT,
  input wire logic XCK_IN,
  output logic XCK_OUT,
  output logic XCK_OE_N_OUT
);
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire usp_mode_t mode = usp_mode_t'(MODE_IN);
  wire is_async = (mode == USP_MODE_ASYNC);
  wire is_spi = (mode == USP_MODE_SPI);
  wire is_slave = (mode == USP_MODE_SYNC) && SYNC_SLAVE_IN;
  wire [3:0] nbits = (DATA_BITS_IN < `USP_MIN_BITS) ? `USP_MIN_BITS :
                     (DATA_BITS_IN > `USP_MAX_BITS) ? `USP_MAX_BITS : DATA_BITS_IN;
  wire par_on = PARITY_EN_IN && !is_spi;
  // modulator only on one instance, async, slow enough
  wire ir_on = (IR_PRESENT != 0) && IR_EN_IN && is_async && (32'(BAUD_INT_IN) >= `USP_IR_MIN_DIV);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic rxd_s1_reg;
  logic rxd_s2_reg;
  logic xck_s1_reg;
  logic xck_s2_reg;
  logic xck_s3_reg;
  // Two flops for RXD, three for XCK; the edge detect only looks at the second and third
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      xck_s1_reg <= 1'b0;
      xck_s2_reg <= 1'b0;
      xck_s3_reg <= 1'b0;
    end else begin
      rxd_s1_reg <= RXD_IN;
      rxd_s2_reg <= rxd_s1_reg;
      xck_s1_reg <= XCK_IN;
      xck_s2_reg <= xck_s1_reg;
      xck_s3_reg <= xck_s2_reg;
    end
  end

  // ----------------------------------------
  // Baud generator and bit clock
  // ----------------------------------------
  logic tick;
  logic xck_reg;
  logic tx_busy_reg;
  // fractional divider shared by both directions
  usp_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .clk(SYS_CLK_IN),
    .rst_n(ARST_N_IN),
    .run_in(TX_EN_IN || RX_EN_IN),
    .div_int_in(BAUD_INT_IN),
    .div_frac_in(BAUD_FRAC_IN),
    .tick_out(tick)
  );
  wire ext_rise = xck_s2_reg && !xck_s3_reg;
  wire ext_fall = !xck_s2_reg && xck_s3_reg;
  // slave edges come from the pin
  wire sync_rise = is_slave ? ext_rise : (tick && !xck_reg && tx_busy_reg);
  wire sync_fall = is_slave ? ext_fall : (tick && xck_reg);
  wire master_clk = !is_async && !is_slave;

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  usp_stream_if #(.W(`USP_WORD_W)) tx_wr ();
  usp_stream_if #(.W(`USP_WORD_W)) tx_rd ();
  assign tx_wr.data = TX_DATA_IN;
  assign tx_wr.valid = TX_VALID_IN;
  // words queue ahead of the shifter
  usp_fifo #(.W(`USP_WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(SYS_CLK_IN),
    .rst_n(ARST_N_IN),
    .wr(tx_wr),
    .rd(tx_rd)
  );
  // Both come from the FIFO's registered ready
  assign TX_READY_OUT = tx_wr.ready;
  // data register empty follows free space
  assign DRE_IRQ_OUT = tx_wr.ready;

  // ----------------------------------------
  // Transmit frame build
  // ----------------------------------------
  logic [`USP_FRAME_W-1:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic [2:0] tx_phase_reg;
  logic txc_reg;
  logic txd_reg;
  logic xck_oe_n_reg;
  wire [`USP_WORD_W-1:0] tx_dmask = tx_rd.data & ~(9'h1FF << nbits);
  wire tx_par = (^tx_dmask) ^ PARITY_ODD_IN;
  // Stop bits are ones, so an extra one above a single stop is harmless
  wire [2:0] tx_tail = par_on ? {2'h3, tx_par} : 3'h7;
  // start, data, parity, stops, LSB first
  wire [`USP_FRAME_W-1:0] tx_async_frame = ({10'h000, tx_tail} << (nbits + 4'h1)) | {3'h0, tx_dmask, 1'b0};
  wire [3:0] tx_async_len = 4'h1 + nbits + {3'h0, par_on} + (TWO_STOP_IN ? 4'h2 : 4'h1);
  // SPI sends bare data, no start or stop
  wire [`USP_FRAME_W-1:0] tx_frame = is_spi ? {4'h0, tx_dmask} : tx_async_frame;
  wire [3:0] tx_len = is_spi ? nbits : tx_async_len;
  wire tx_bit_end = tx_busy_reg && (is_async ? (tick && tx_phase_reg == `USP_PHASE_LAST) : sync_fall);
  wire tx_last = (tx_left_reg == 4'h1);
  // next word loads in the last bit's final cycle
  wire tx_load = (!tx_busy_reg || (tx_bit_end && tx_last)) && tx_rd.valid && TX_EN_IN;
  assign tx_rd.ready = tx_load;
  // complete when shifter and queue both drain
  wire txc_set = tx_bit_end && tx_last && !tx_load;
  // low pulse in the bit centre for a zero
  wire ir_pulse = tx_busy_reg && !tx_shift_reg[0] &&
                  (tx_phase_reg == `USP_IR_PULSE_A || tx_phase_reg == `USP_IR_PULSE_B);
  wire txd_next = ir_on ? !ir_pulse : (tx_busy_reg ? tx_shift_reg[0] : !is_spi);

  // ----------------------------------------
  // Transmit shifter
  // ----------------------------------------
  // runs apart from the receiver
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_shift_reg <= '1;
      tx_left_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= tx_frame;
      tx_left_reg <= tx_len;
      tx_busy_reg <= 1'b1;
    end else if (tx_bit_end) begin
      tx_shift_reg <= {1'b1, tx_shift_reg[`USP_FRAME_W-1:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
      tx_busy_reg <= !tx_last;
    end
  end

  // Bit phase restarts with each frame so bit edges stay on tick boundaries
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_phase_reg <= 3'h0;
    end else if (tx_load) begin
      tx_phase_reg <= 3'h0;
    end else if (tick) begin
      tx_phase_reg <= tx_phase_reg + 3'h1;
    end
  end

  // master clock toggles once per tick, two ticks a bit
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      xck_reg <= 1'b0;
    end else if (master_clk && tick && (tx_busy_reg || xck_reg)) begin
      xck_reg <= !xck_reg;
    end
  end

  // same pin drive in both modes; enable low while driving
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      txd_reg <= 1'b1;
      xck_oe_n_reg <= 1'b1;
      txc_reg <= 1'b0;
    end else begin
      txd_reg <= txd_next;
      xck_oe_n_reg <= !master_clk;
      txc_reg <= txc_set || (txc_reg && !TXC_CLR_IN);
    end
  end
  assign TXD_OUT = txd_reg;
  assign XCK_OUT = xck_reg;
  assign XCK_OE_N_OUT = xck_oe_n_reg;
  assign TXC_IRQ_OUT = txc_reg;

  // ----------------------------------------
  // Receive sampling
  // ----------------------------------------
  usp_rx_state_t rx_state_reg;
  usp_rx_state_t rx_state_next;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_cnt_next;
  logic [2:0] rx_phase_reg;
  logic [`USP_WORD_W-1:0] rx_data_reg;
  logic rx_perr_reg;
  logic vote_a_reg;
  logic vote_b_reg;
  logic ir_low_reg;
  // majority of three centre samples filters glitches
  wire vote = (vote_a_reg & vote_b_reg) | (vote_a_reg & rxd_s2_reg) | (vote_b_reg & rxd_s2_reg);
  // any pulse seen in the bit reads as zero
  wire rx_val = !is_async ? rxd_s2_reg : (ir_on ? !(ir_low_reg || !rxd_s2_reg) : vote);
  // decide at the third centre sample
  wire rx_strobe = (rx_state_reg != USP_RX_IDLE) &&
                   (is_async ? (tick && rx_phase_reg == `USP_VOTE_C) : sync_rise);
  wire rx_start_async = RX_EN_IN && is_async && rx_state_reg == USP_RX_IDLE && tick && !rxd_s2_reg;
  wire rx_start_sync = RX_EN_IN && rx_state_reg == USP_RX_IDLE &&
                       ((is_spi && tx_load) || (!is_async && !is_spi && sync_rise && !rxd_s2_reg));
  wire rx_last = (rx_cnt_reg == nbits - 4'h1);
  wire [`USP_WORD_W-1:0] rx_data_fin = rx_data_reg | (9'(rx_val) << rx_cnt_reg);

  // Vote samples and pulse catcher, one bit at a time
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      vote_a_reg <= 1'b1;
      vote_b_reg <= 1'b1;
      ir_low_reg <= 1'b0;
    end else if (tick) begin
      vote_a_reg <= (rx_phase_reg == `USP_VOTE_A) ? rxd_s2_reg : vote_a_reg;
      vote_b_reg <= (rx_phase_reg == `USP_VOTE_B) ? rxd_s2_reg : vote_b_reg;
      ir_low_reg <= rx_start_async || ((rx_phase_reg != `USP_PHASE_LAST) && (ir_low_reg || !rxd_s2_reg));
    end
  end

  // ----------------------------------------
  // Receive sequence
  // ----------------------------------------
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    case (rx_state_reg)
      USP_RX_START: begin
        // start gone by mid-bit is false
        rx_state_next = rx_val ? USP_RX_IDLE : USP_RX_BITS;
        rx_cnt_next = 4'h0;
      end
      USP_RX_BITS: begin
        rx_cnt_next = rx_cnt_reg + 4'h1;
        if (rx_last) begin
          rx_state_next = is_spi ? USP_RX_IDLE : (par_on ? USP_RX_PAR : USP_RX_STOP);
        end
      end
      USP_RX_PAR: begin
        rx_state_next = USP_RX_STOP;
      end
      default: begin
        rx_state_next = USP_RX_IDLE;
      end
    endcase
  end

  // Only the first stop bit is checked so a second one may overlap
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_state_reg <= USP_RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_data_reg <= '0;
      rx_perr_reg <= 1'b0;
    end else if (!RX_EN_IN) begin
      rx_state_reg <= USP_RX_IDLE;
    end else if (rx_start_async || rx_start_sync) begin
      rx_state_reg <= rx_start_async ? USP_RX_START : USP_RX_BITS;
      rx_cnt_reg <= 4'h0;
      rx_data_reg <= '0;
      rx_perr_reg <= 1'b0;
    end else if (rx_strobe) begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_data_reg <= (rx_state_reg == USP_RX_BITS) ? rx_data_fin : rx_data_reg;
      if (rx_state_reg == USP_RX_PAR) begin
        rx_perr_reg <= rx_val != ((^rx_data_reg) ^ PARITY_ODD_IN);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_phase_reg <= 3'h0;
    end else if (rx_start_async) begin
      rx_phase_reg <= 3'h1;
    end else if (tick) begin
      rx_phase_reg <= rx_phase_reg + 3'h1;
    end
  end

  // ----------------------------------------
  // Receive holding register
  // ----------------------------------------
  logic rx_valid_reg;
  logic [`USP_WORD_W-1:0] rx_out_reg;
  logic ferr_reg;
  logic perr_reg;
  logic ovr_reg;
  wire rx_done = rx_strobe && RX_EN_IN &&
                 ((rx_state_reg == USP_RX_BITS && rx_last && is_spi) || rx_state_reg == USP_RX_STOP);
  // Only the last SPI bit still needs merging; a stop level must stay out of the word
  wire [`USP_WORD_W-1:0] rx_word = (rx_state_reg == USP_RX_BITS) ? rx_data_fin : rx_data_reg;
  wire [3:0] addr_idx = nbits - 4'h1;
  // without the address mark, frames are dropped
  wire mp_drop = MPCM_IN && !is_spi && !rx_word[addr_idx];
  wire rx_deliver = rx_done && !mp_drop;
  // a full holding register loses the new word
  wire ovr_set = rx_deliver && rx_valid_reg && !RX_READY_IN;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_valid_reg <= 1'b0;
      rx_out_reg <= '0;
      ferr_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else if (rx_deliver && !ovr_set) begin
      rx_valid_reg <= 1'b1;
      rx_out_reg <= rx_word;
      // stop bit low marks a framing error
      ferr_reg <= !is_spi && !rx_val;
      perr_reg <= !is_spi && rx_perr_reg;
    end else if (rx_valid_reg && RX_READY_IN) begin
      rx_valid_reg <= 1'b0;
    end
  end

  // Overrun is sticky; a new overrun beats a clear in the same cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ovr_reg <= 1'b0;
    end else begin
      ovr_reg <= ovr_set || (ovr_reg && !OVERRUN_CLR_IN);
    end
  end
  assign RX_VALID_OUT = rx_valid_reg;
  // receive complete while a word waits
  assign RXC_IRQ_OUT = rx_valid_reg;
  assign RX_DATA_OUT = rx_out_reg;
  assign RX_FRAME_ERR_OUT = ferr_reg;
  assign RX_PARITY_ERR_OUT = perr_reg;
  assign OVERRUN_OUT = ovr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  a_async_bit_rate: assert property ((is_async && tx_bit_end) |=> !tx_bit_end [*7]) else $error("async bit too short");
  a_sync_bit_rate: assert property ((master_clk && sync_fall) |=> !sync_fall) else $error("sync clock too fast");
  a_spi_clock_half: assert property ((is_spi && $rose(xck_reg)) |=> !$rose(xck_reg)) else $error("spi clock too fast");
  a_false_start: assert property ((rx_state_reg == USP_RX_START && rx_strobe && rx_val) |=> rx_state_reg == USP_RX_IDLE) else $error("false start kept");
  a_overrun_flag: assert property (ovr_set |=> OVERRUN_OUT && RX_VALID_OUT) else $error("overrun not flagged");
  a_parity_check: assert property ((rx_state_reg == USP_RX_PAR && rx_strobe && RX_EN_IN && rx_val == ((^rx_data_reg) ^ PARITY_ODD_IN)) |=> !rx_perr_reg) else $error("good parity flagged");
  a_mpcm_drop: assert property ((rx_done && mp_drop && !rx_valid_reg) |=> !RX_VALID_OUT) else $error("unaddressed frame kept");
  a_txc_set: assert property (txc_set |=> TXC_IRQ_OUT) else $error("transmit complete missed");
  a_spi_no_start: assert property (is_spi |-> rx_state_reg != USP_RX_START) else $error("spi used start detect");
  a_tx_gapless: assert property ((tx_bit_end && tx_last && tx_rd.valid && TX_EN_IN) |=> tx_busy_reg) else $error("gap between frames");
  c_async_frame: cover property (is_async && rx_deliver);
  c_overrun: cover property (ovr_set);
  c_spi_xfer: cover property (is_spi && txc_set);
endmodule
`default_nettype wire

// File: verification/usp_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
// Remote async node: drives our receive pin, samples our transmit pin
module usp_remote_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  // Line rests high between frames, as a pulled-up pin does
  initial rxd_out = 1'h1;
  // Hold one level for a whole bit time
  task automatic put(input logic b);
    rxd_out = b;
    repeat (BIT_CYC) @(posedge clk_in);
    #1;
  endtask
  // start, data low bit first, parity, stop
  task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic odd, input logic stp);
    logic [8:0] m;
    m = (9'h001 << nb) - 9'h001;
    put(1'h0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (pe) put(odd ^ (^(d & m)));
    put(stp);
    put(1'h1);
  endtask
  // Low pulse far too short to be a start
  task automatic pulse(input int n);
    rxd_out = 1'h0;
    repeat (n) @(posedge clk_in);
    #1;
    rxd_out = 1'h1;
  endtask
  // Sample the far transmit pin at mid bit, timed from the start edge
  task automatic recv(input int nb, output logic [8:0] d);
    d = 9'h000;
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge clk_in);
      // Look just after the edge so the pin has settled
      #1 d[i] = txd_in;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import usp_pkg::*;;
  logic clk = 1'h0, rst_n = 1'h0, tx_en = 1'h1, rx_en = 1'h1, slave = 1'h0, two_stop = 1'h0;
  logic par_en = 1'h0, par_odd = 1'h0, mpcm = 1'h0, tx_valid = 1'h0, rx_ready = 1'h1;
  logic ovr_clr = 1'h0, txc_clr = 1'h0;
  logic [1:0] mode = USP_MODE_ASYNC;
  logic [3:0] nbits = 4'h8;
  logic [8:0] tx_data = 9'h000;
  logic [8:0] rx_data;
  logic rx_valid, tx_ready, ferr, perr, ovr, txc, dre, rxc, txd, rxd, xck, xck_oe_n;
  int tests_run = 0;
  int n_mismatch = 0;
  int cyc = 0;
  // Bit time is 8 ticks of 2 cycles each
  usp_serial_port dut_u (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .TX_EN_IN(tx_en), .RX_EN_IN(rx_en),
    .MODE_IN(mode), .SYNC_SLAVE_IN(slave), .DATA_BITS_IN(nbits), .TWO_STOP_IN(two_stop),
    .PARITY_EN_IN(par_en), .PARITY_ODD_IN(par_odd), .MPCM_IN(mpcm), .IR_EN_IN(1'h0),
    .BAUD_INT_IN(12'h002), .BAUD_FRAC_IN(4'h0), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid),
    .TX_READY_OUT(tx_ready), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid), .RX_READY_IN(rx_ready),
    .RX_FRAME_ERR_OUT(ferr), .RX_PARITY_ERR_OUT(perr), .OVERRUN_OUT(ovr), .OVERRUN_CLR_IN(ovr_clr),
    .TXC_IRQ_OUT(txc), .TXC_CLR_IN(txc_clr), .DRE_IRQ_OUT(dre), .RXC_IRQ_OUT(rxc), .RXD_IN(rxd),
    .TXD_OUT(txd), .XCK_IN(1'h0), .XCK_OUT(xck), .XCK_OE_N_OUT(xck_oe_n));
  usp_remote_node #(.BIT_CYC(16)) peer_u (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
  always #5 clk = ~clk;
  // Ceiling far above the few thousand cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Wide enough for a flag or two packed above a nine-bit word
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a received word; valid may stand one cycle only
  task automatic wait_rx(input int lim, output logic got);
    got = 1'h0;
    repeat (lim) begin
      tick(1);
      if (rx_valid === 1'h1) begin
        got = 1'h1;
        return;
      end
    end
  endtask
  task automatic rx_one(input logic [8:0] d, input logic odd, input logic stp, output logic got);
    fork
      peer_u.send(d, int'(nbits), par_en, odd, stp);
      wait_rx(400, got);
    join
  endtask
  task automatic t_duplex;
    logic [8:0] w0, w1;
    logic got;
    fork
      begin
        tx_data = 9'h0A5;
        tx_valid = 1'h1;
        tick(1);
        tx_data = 9'h13C;
        tick(1);
        tx_valid = 1'h0;
      end
      begin
        peer_u.recv(8, w0);
        peer_u.recv(8, w1);
      end
      rx_one(9'h05A, 1'h0, 1'h1, got);
    join
    check("tx word 0", w0, 9'h0A5);
    check("tx word 1", w1, 9'h03C);
    check("rx word", rx_data, 9'h05A);
    tick(40);
    check("tx complete", {rxc, dre, txc}, 9'h003);
    txc_clr = 1'h1;
    tick(1);
    txc_clr = 1'h0;
    tick(1);
    check("tx complete clear", txc, 9'h000);
  endtask
  task automatic t_parity;
    logic got;
    nbits = 4'h7;
    par_en = 1'h1;
    // Second half of the passes sends the wrong sense of parity
    for (int k = 0; k < 4; k++) begin
      par_odd = k[0];
      rx_one(9'h035, k[0] ^ k[1], 1'h1, got);
      check("parity error", {got, perr}, {7'h00, 1'h1, k[1]});
      check("parity data", rx_data[6:0], 9'h035);
    end
    par_en = 1'h0;
    nbits = 4'h8;
  endtask
  task automatic t_errors;
    logic got;
    rx_one(9'h0C3, 1'h0, 1'h0, got);
    check("framing error", {got, ferr, rx_data}, {1'h1, 1'h1, 9'h0C3});
    rx_ready = 1'h0;
    rx_one(9'h011, 1'h0, 1'h1, got);
    rx_one(9'h022, 1'h0, 1'h1, got);
    tick(2);
    check("overrun", {ovr, rx_data}, {1'h1, 9'h011});
    rx_ready = 1'h1;
    ovr_clr = 1'h1;
    tick(1);
    ovr_clr = 1'h0;
    tick(1);
    check("overrun clear", ovr, 9'h000);
    peer_u.pulse(3);
    wait_rx(200, got);
    check("false start", got, 9'h000);
  endtask
  task automatic t_mpcm;
    logic got;
    nbits = 4'h9;
    mpcm = 1'h1;
    rx_one(9'h0AB, 1'h0, 1'h1, got);
    check("unaddressed frame", got, 9'h000);
    rx_one(9'h1CD, 1'h0, 1'h1, got);
    check("address frame", {got, rx_data}, {1'h1, 9'h1CD});
    mpcm = 1'h0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    check("reset levels", {xck_oe_n, xck, txd, tx_ready, dre, rx_valid, txc, ovr}, 11'h0B8);
    rst_n = 1'h1;
    tick(2);
    t_duplex();
    t_parity();
    t_errors();
    t_mpcm();
    test_done();
  end
endmodule
`default_nettype wire
